// ---- bcfr_props.sv ----
// Purpose: Concurrent checks on the fault reporting ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   One lane per rule keeps the checker small.
module bcfr_props
    import bcfr_pkg::*;
#(
    parameter logic [ID_W-1:0] CORE_ID [NMID] = '{4'h0, 4'h1}  // Expected master ids
)
(
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                rst_n,
    // Crossbar and feedback
    input wire logic [NPORT-1:0]    xp_valid,
    input wire logic [NPORT-1:0]    xp_resp_valid,
    input wire logic [NPORT-1:0]    xp_resp_err,
    input wire logic [NFB-1:0]      fb_valid,
    input wire logic [CTRL_W-1:0]   fb_sent [NFB],
    input wire logic [CTRL_W-1:0]   fb_back [NFB],
    // Rmw slave side
    input wire logic [NRMW-1:0]     slv_rd,
    input wire logic [NRMW-1:0]     slv_wr,
    input wire logic [NRMW-1:0]     slv_lock,
    input wire logic [NRMW-1:0]     slv_ack,
    input wire logic [NRMW-1:0]     rmw_done,
    // Core status and collector
    input wire logic [NCORE-1:0]    mchk,
    input wire logic [NMID-1:0]     dbus_valid,
    input wire logic [ID_W-1:0]     dbus_id [NMID],
    input wire logic                ls_enable,
    input wire logic [FAULT_W-1:0]  fake_fault,
    input wire logic [FAULT_W-1:0]  fault_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_resp_timing: assert property (xp_valid[0] |=> xp_resp_valid[0])
        else $error("crossbar answer not one cycle after request");
    chk_refuse_fault: assert property (xp_resp_valid[0] && xp_resp_err[0] |=> fault_q[31])
        else $error("refusal not reported");
    chk_fb_fault: assert property (fb_valid[0] && fb_sent[0] != fb_back[0] |=> fault_q[33])
        else $error("feedback mismatch not reported");
    // Write must follow the read acknowledge with no idle cycle
    chk_rmw_no_idle: assert property (slv_rd[0] && slv_ack[0] |=> slv_wr[0] && slv_lock[0])
        else $error("rmw write not back to back");
    chk_rmw_done: assert property (slv_wr[0] && slv_ack[0] |-> rmw_done[0])
        else $error("rmw done missing at write ack");
    chk_mchk_fault: assert property (mchk[2] |=> fault_q[82])
        else $error("machine check not reported");
    chk_mid_fault: assert property (dbus_valid[1] && dbus_id[1] != CORE_ID[1] |=> fault_q[95])
        else $error("bad master id not reported");
    chk_ls_off: assert property (!ls_enable |=> fault_q[111])
        else $error("lockstep disable not reported");
    chk_fake_inject: assert property (fake_fault[11] |=> fault_q[11])
        else $error("fake fault not forced");
    // Sticky: a set bit never drops outside reset
    chk_fault_sticky: assert property ((fault_q & $past(fault_q)) == $past(fault_q))
        else $error("fault bit cleared without reset");
endmodule

// ---- bcfr_rpu_port.sv ----
// Purpose: Package of constants and one region-protection crossbar port checker.
// Assumes: Single sys_clk domain, synchronous active-low rst_n.
// Notes:   Fault numbers index the fault vector driven toward the collector.
package bcfr_pkg;
    localparam int FAULT_W    = 128;          // Width of the numbered fault vector
    localparam int ADDR_W     = 32;           // Bus address width
    localparam int DATA_W     = 32;           // Bus data width
    localparam int CTRL_W     = 8;            // Memory control vector width
    localparam int ID_W       = 4;            // Master identifier width
    localparam int LS_W       = 32;           // Lockstep comparison vector width
    localparam int NREG       = 4;            // Region descriptors
    localparam int NPORT      = 4;            // Crossbar ports: 0, 1, 2, backdoor
    localparam int NFB        = 12;           // Feedback checkers: 3 cores x 4 targets
    localparam int NRMW       = 2;            // Cores with a checked rmw sequencer
    localparam int NCORE      = 3;            // Cores with machine check
    localparam int NMID       = 2;            // Cores with master identity monitors
    // Fault numbers
    localparam int FLT_REFUSE [NPORT] = '{31, 32, 107, 98};
    localparam int FLT_WRONG  [NPORT] = '{29, 30, 108, 99};
    localparam int FLT_FB     [NFB]   = '{33, 34, 35, 36, 37, 38, 39, 40, 41, 42, 43, 44};
    localparam int FLT_RMW    [NRMW]  = '{71, 73};
    localparam int FLT_MCHK   [NCORE] = '{80, 81, 82};
    localparam int FLT_MID_D  [NMID]  = '{116, 95};
    localparam int FLT_MID_I  [NMID]  = '{117, 96};
    localparam int FLT_LS_MISMATCH    = 11;
    localparam int FLT_LS_OFF         = 111;
    // Reset values
    localparam logic [FAULT_W-1:0] FAULT_RST = '0;

    // Rmw sequencer states
    typedef enum logic [1:0] {BCFR_IDLE, BCFR_READ, BCFR_WRITE} bcfr_rmw_e;

    // Access allowed when some region covers the address with the needed right
    function automatic logic bcfr_allowed(
        input logic [ADDR_W-1:0]            addr,
        input logic                         wr,
        input logic [NREG-1:0][ADDR_W-1:0]  lo,
        input logic [NREG-1:0][ADDR_W-1:0]  hi,
        input logic [NREG-1:0]              rd_ok,
        input logic [NREG-1:0]              wr_ok
    );
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < NREG; i++)
        begin
            if (addr >= lo[i] && addr <= hi[i] && (wr ? wr_ok[i] : rd_ok[i]))
            begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction
endpackage

module bcfr_rpu_port
    import bcfr_pkg::*;
(
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    // Transaction from the crossbar port
    input  wire logic                        req_valid,
    input  wire logic [ADDR_W-1:0]           req_addr,
    input  wire logic                        req_write,
    // Region descriptors
    input  wire logic [NREG-1:0][ADDR_W-1:0] region_lo,
    input  wire logic [NREG-1:0][ADDR_W-1:0] region_hi,
    input  wire logic [NREG-1:0]             region_rd,
    input  wire logic [NREG-1:0]             region_wr,
    // Answer and monitor events
    output logic                             resp_valid_q,
    output logic                             resp_err_q,
    output logic                             wrong_q
);
    logic              chk_valid_q;   // Monitor's own copy of the request
    logic [ADDR_W-1:0] chk_addr_q;
    logic              chk_write_q;

    // Decision path: answer one cycle after the request
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            resp_valid_q <= 1'b0;
            resp_err_q   <= 1'b0;
        end
        else
        begin
            resp_valid_q <= req_valid;
            resp_err_q   <= req_valid &&
                !bcfr_allowed(req_addr, req_write, region_lo, region_hi, region_rd, region_wr);
        end
    end

    // Monitor keeps an independent request copy so one upset flop is caught
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            chk_valid_q <= 1'b0;
            chk_addr_q  <= '0;
            chk_write_q <= 1'b0;
        end
        else
        begin
            chk_valid_q <= req_valid;
            chk_addr_q  <= req_addr;
            chk_write_q <= req_write;
        end
    end

    // Wrong grant or wrong refusal, flagged a cycle after the answer
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wrong_q <= 1'b0;
        end
        else
        begin
            wrong_q <= (resp_valid_q != chk_valid_q) || (chk_valid_q && (resp_err_q ==
                bcfr_allowed(chk_addr_q, chk_write_q, region_lo, region_hi, region_rd, region_wr)));
        end
    end
endmodule

// ---- bcfr_slave_model.sv ----
// Purpose: Slave memory behind one rmw sequencer, one data word.
// Assumes: Request held until ack; ack lasts one cycle.
// Notes:   Read data toggles outside the ack cycle so stale use shows.
module bcfr_slave_model
    import bcfr_pkg::*;
#(
    parameter logic [DATA_W-1:0] INIT = 32'h0  // Word held after reset
)
(
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                rst_n,
    // Request from the sequencer
    input wire logic [3:0]          lat,
    input wire logic                rd,
    input wire logic                wr,
    input wire logic                lock,
    input wire logic [DATA_W-1:0]   wdata,
    // Answer and stored word
    output logic                    ack_q,
    output logic [DATA_W-1:0]       rdata_q,
    output logic [DATA_W-1:0]       mem_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;  // Wait states so far
    // Answer after lat wait states; only a locked request is served
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ack_q   <= 1'b0;
            cnt_q   <= 4'h0;
            mem_q   <= INIT;
            rdata_q <= ~INIT;
        end
        else if (!ack_q && (rd || wr) && lock && cnt_q == lat)
        begin
            ack_q   <= 1'b1;
            rdata_q <= mem_q;
            if (wr)
                mem_q <= wdata;
        end
        else
        begin
            ack_q   <= 1'b0;
            cnt_q   <= (!ack_q && (rd || wr)) ? cnt_q + 4'h1 : 4'h0;
            rdata_q <= ~rdata_q;
        end
    end
endmodule

// ---- bcfr_top.sv ----
// Purpose: Bus and core fault reporting toward the fault collection unit.
// Assumes: All inputs come from logic on sys_clk; no synchronisers needed.
// Notes:   Fault bits are sticky and clear only on reset.
module bcfr_top
    import bcfr_pkg::*;
#(
    parameter logic [ID_W-1:0] CORE_ID [NMID] = '{4'h0, 4'h1}  // Expected master ids
)
(
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    // Crossbar port transactions
    input  wire logic [NPORT-1:0]            xp_valid,
    input  wire logic [ADDR_W-1:0]           xp_addr [NPORT],
    input  wire logic [NPORT-1:0]            xp_write,
    output logic      [NPORT-1:0]            xp_resp_valid,
    output logic      [NPORT-1:0]            xp_resp_err,
    // Region descriptors
    input  wire logic [NREG-1:0][ADDR_W-1:0] region_lo,
    input  wire logic [NREG-1:0][ADDR_W-1:0] region_hi,
    input  wire logic [NREG-1:0]             region_rd,
    input  wire logic [NREG-1:0]             region_wr,
    // Memory control feedback, index core*4 + target (imem, dmem, icache, dcache)
    input  wire logic [NFB-1:0]              fb_valid,
    input  wire logic [CTRL_W-1:0]           fb_sent [NFB],
    input  wire logic [CTRL_W-1:0]           fb_back [NFB],
    // Rmw requests from cores 0 and 1
    input  wire logic [NRMW-1:0]             rmw_req,
    input  wire logic [ADDR_W-1:0]           rmw_addr [NRMW],
    input  wire logic [DATA_W-1:0]           rmw_wdata [NRMW],
    input  wire logic [DATA_W-1:0]           rmw_wmask [NRMW],
    output logic      [NRMW-1:0]             rmw_done,
    // Rmw slave side
    output logic      [NRMW-1:0]             slv_rd,
    output logic      [NRMW-1:0]             slv_wr,
    output logic      [NRMW-1:0]             slv_lock,
    output logic      [ADDR_W-1:0]           slv_addr [NRMW],
    output logic      [DATA_W-1:0]           slv_wdata [NRMW],
    input  wire logic [NRMW-1:0]             slv_ack,
    input  wire logic [DATA_W-1:0]           slv_rdata [NRMW],
    // Core status
    input  wire logic [NCORE-1:0]            mchk,
    input  wire logic [NMID-1:0]             dbus_valid,
    input  wire logic [ID_W-1:0]             dbus_id [NMID],
    input  wire logic [NMID-1:0]             ibus_valid,
    input  wire logic [ID_W-1:0]             ibus_id [NMID],
    // Lockstep pair of the safety core
    input  wire logic [LS_W-1:0]             ls_main,
    input  wire logic [LS_W-1:0]             ls_replica,
    input  wire logic                        ls_enable,
    // Fault collection unit side
    input  wire logic [FAULT_W-1:0]          fake_fault,
    output logic      [FAULT_W-1:0]          fault_q
);
    logic [NPORT-1:0]   wrong;              // Decision monitor events
    logic [FAULT_W-1:0] event_vec;          // Faults seen this cycle
    logic [FAULT_W-1:0] inject_mask;        // Lines the fake path may force
    logic [FAULT_W-1:0] fault_d;
    bcfr_rmw_e          st_q  [NRMW];       // Rmw state
    bcfr_rmw_e          dup_q [NRMW];       // Shadow copy for control checking
    bcfr_rmw_e          st_d  [NRMW];
    logic [DATA_W-1:0]  wdata_q [NRMW];     // Request data held through sequence
    logic [DATA_W-1:0]  wmask_q [NRMW];
    logic [NRMW-1:0]    rmw_err;

    // One checker per crossbar port
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        bcfr_rpu_port u_port (
            .sys_clk      (sys_clk),
            .rst_n        (rst_n),
            .req_valid    (xp_valid[p]),
            .req_addr     (xp_addr[p]),
            .req_write    (xp_write[p]),
            .region_lo    (region_lo),
            .region_hi    (region_hi),
            .region_rd    (region_rd),
            .region_wr    (region_wr),
            .resp_valid_q (xp_resp_valid[p]),
            .resp_err_q   (xp_resp_err[p]),
            .wrong_q      (wrong[p])
        );
    end

    // Rmw sequencers for cores 0 and 1
    for (genvar c = 0; c < NRMW; c++)
    begin : g_rmw
        // Next state: write issued the cycle after the read is acknowledged
        always_comb
        begin
            st_d[c] = st_q[c];
            case (st_q[c])
                BCFR_IDLE:  if (rmw_req[c]) st_d[c] = BCFR_READ;
                BCFR_READ:  if (slv_ack[c]) st_d[c] = BCFR_WRITE;
                BCFR_WRITE: if (slv_ack[c]) st_d[c] = BCFR_IDLE;
                default:    st_d[c] = BCFR_IDLE;
            endcase
        end

        // State and its shadow load the same next value
        always_ff @(posedge sys_clk)
        begin
            if (!rst_n)
            begin
                st_q[c]  <= BCFR_IDLE;
                dup_q[c] <= BCFR_IDLE;
            end
            else
            begin
                st_q[c]  <= st_d[c];
                dup_q[c] <= st_d[c];
            end
        end

        // Capture request, then merge read data under the mask
        always_ff @(posedge sys_clk)
        begin
            if (!rst_n)
            begin
                slv_addr[c]  <= '0;
                wdata_q[c]   <= '0;
                wmask_q[c]   <= '0;
                slv_wdata[c] <= '0;
            end
            else if (st_q[c] == BCFR_IDLE && rmw_req[c])
            begin
                slv_addr[c] <= rmw_addr[c];
                wdata_q[c]  <= rmw_wdata[c];
                wmask_q[c]  <= rmw_wmask[c];
            end
            else if (st_q[c] == BCFR_READ && slv_ack[c])
            begin
                slv_wdata[c] <= (slv_rdata[c] & ~wmask_q[c]) | (wdata_q[c] & wmask_q[c]);
            end
        end

        // Strobes; lock covers read and write so the slave stays ours
        assign slv_rd[c]   = (st_q[c] == BCFR_READ);
        assign slv_wr[c]   = (st_q[c] == BCFR_WRITE);
        assign slv_lock[c] = (st_q[c] != BCFR_IDLE);
        assign rmw_done[c] = (st_q[c] == BCFR_WRITE) && slv_ack[c];
        // Control error: shadow disagrees or state leaves the legal set
        assign rmw_err[c]  = (st_q[c] != dup_q[c]) || (st_q[c] == bcfr_rmw_e'(2'h3));
    end

    // Gather this cycle's events by fault number
    always_comb
    begin
        event_vec = '0;
        for (int p = 0; p < NPORT; p++)
        begin
            event_vec[FLT_REFUSE[p]] = xp_resp_valid[p] && xp_resp_err[p];
            event_vec[FLT_WRONG[p]]  = wrong[p];
        end
        // Feedback mismatch per core and target
        for (int f = 0; f < NFB; f++)
        begin
            event_vec[FLT_FB[f]] = fb_valid[f] && (fb_sent[f] != fb_back[f]);
        end
        for (int c = 0; c < NRMW; c++)
        begin
            event_vec[FLT_RMW[c]] = rmw_err[c];
        end
        for (int c = 0; c < NCORE; c++)
        begin
            event_vec[FLT_MCHK[c]] = mchk[c];
        end
        for (int c = 0; c < NMID; c++)
        begin
            event_vec[FLT_MID_D[c]] = dbus_valid[c] && dbus_id[c] != CORE_ID[c];
            event_vec[FLT_MID_I[c]] = ibus_valid[c] && ibus_id[c] != CORE_ID[c];
        end
        // Replica compared only while lockstep runs
        event_vec[FLT_LS_MISMATCH] = ls_enable && (ls_main != ls_replica);
        event_vec[FLT_LS_OFF]      = !ls_enable;
    end

    // Injectable lines; monitor, refusal, rmw and machine check errors have no fake path
    always_comb
    begin
        inject_mask = '0;
        for (int f = 0; f < NFB; f++)
        begin
            inject_mask[FLT_FB[f]] = 1'b1;
        end
        for (int c = 0; c < NMID; c++)
        begin
            inject_mask[FLT_MID_D[c]] = 1'b1;
            inject_mask[FLT_MID_I[c]] = 1'b1;
        end
        inject_mask[FLT_LS_MISMATCH] = 1'b1;
        inject_mask[FLT_LS_OFF]      = 1'b1;
        fault_d = fault_q | event_vec | (fake_fault & inject_mask);
    end

    // Sticky registered faults, glitch free toward the collector
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            fault_q <= FAULT_RST;
        end
        else
        begin
            fault_q <= fault_d;
        end
    end
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for bus and core fault reporting.
// Assumes: Inputs change at the falling edge; faults are sticky.
// Notes:   Each row starts from reset so its fault shows alone.
module tb_top
    import bcfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int kind; int idx; int fnum;} bcfr_row_s;  // Kind, lane, fault or -1
    logic sys_clk = 1'b0, rst_n = 1'b0, ls_enable;
    logic [NPORT-1:0] xp_valid, xp_write, xp_resp_valid, xp_resp_err;
    logic [ADDR_W-1:0] xp_addr [NPORT], rmw_addr [NRMW], slv_addr [NRMW];
    logic [NREG-1:0][ADDR_W-1:0] region_lo, region_hi;
    logic [NREG-1:0] region_rd, region_wr;
    logic [NFB-1:0] fb_valid;
    logic [CTRL_W-1:0] fb_sent [NFB], fb_back [NFB];
    logic [NRMW-1:0] rmw_req, rmw_done, slv_rd, slv_wr, slv_lock, slv_ack, seen;
    logic [DATA_W-1:0] rmw_wdata [NRMW], rmw_wmask [NRMW], slv_wdata [NRMW];
    logic [DATA_W-1:0] slv_rdata [NRMW], mem [NRMW];
    logic [NCORE-1:0] mchk;
    logic [NMID-1:0] dbus_valid, ibus_valid;
    logic [ID_W-1:0] dbus_id [NMID], ibus_id [NMID];
    logic [LS_W-1:0] ls_main, ls_replica;
    logic [FAULT_W-1:0] fake_fault, fault_q;
    int num_errors = 0, comparisons = 0;
    // Ordinary cases; fake rows at the end, four of them not injectable
    bcfr_row_s rows [36] = '{'{0,0,31}, '{0,1,32}, '{0,2,107}, '{0,3,98},
        '{1,0,33}, '{1,1,34}, '{1,2,35}, '{1,3,36}, '{1,4,37}, '{1,5,38}, '{1,6,39},
        '{1,7,40}, '{1,8,41}, '{1,9,42}, '{1,10,43}, '{1,11,44}, '{2,0,80}, '{2,1,81},
        '{2,2,82}, '{3,0,116}, '{3,1,95}, '{4,0,117}, '{4,1,96}, '{5,0,11},
        '{6,33,33}, '{6,44,44}, '{6,116,116}, '{6,95,95}, '{6,117,117}, '{6,96,96},
        '{6,11,11}, '{6,111,111}, '{6,31,-1}, '{6,29,-1}, '{6,71,-1}, '{6,80,-1}};
    always #20 sys_clk = ~sys_clk;
    bcfr_top uut (.sys_clk, .rst_n, .xp_valid, .xp_addr, .xp_write, .xp_resp_valid,
        .xp_resp_err, .region_lo, .region_hi, .region_rd, .region_wr, .fb_valid, .fb_sent,
        .fb_back, .rmw_req, .rmw_addr, .rmw_wdata, .rmw_wmask, .rmw_done, .slv_rd, .slv_wr,
        .slv_lock, .slv_addr, .slv_wdata, .slv_ack, .slv_rdata, .mchk, .dbus_valid, .dbus_id,
        .ibus_valid, .ibus_id, .ls_main, .ls_replica, .ls_enable, .fake_fault, .fault_q);
    // Lane 0 answers promptly, lane 1 after three wait states
    for (genvar i = 0; i < NRMW; i++)
    begin : g_slv
        bcfr_slave_model #(.INIT(32'h1234_5678)) u_slv (.sys_clk(sys_clk), .rst_n(rst_n),
            .lat(i ? 4'h3 : 4'h0), .rd(slv_rd[i]), .wr(slv_wr[i]), .lock(slv_lock[i]),
            .wdata(slv_wdata[i]), .ack_q(slv_ack[i]), .rdata_q(slv_rdata[i]), .mem_q(mem[i]));
    end
    task automatic chk(input logic [FAULT_W-1:0] got, input logic [FAULT_W-1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Quiet ports: matching feedback and lockstep, valid ids on both buses
    task automatic idle();
        xp_valid = '0;
        xp_write = '0;
        fb_valid = '1;
        mchk = '0;
        dbus_valid = '1;
        ibus_valid = '1;
        dbus_id = '{4'h0, 4'h1};
        ibus_id = '{4'h0, 4'h1};
        ls_replica = ls_main;
        fake_fault = '0;
        fb_back = fb_sent;
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
    endtask
    task automatic run_row(input bcfr_row_s r);
        logic [FAULT_W-1:0] exp;
        exp = '0;
        if (r.fnum >= 0)
            exp[r.fnum] = 1'b1;
        do_reset();
        case (r.kind)
            0: xp_valid[r.idx] = 1'b1;
            1: fb_back[r.idx] = ~fb_sent[r.idx];
            2: mchk[r.idx] = 1'b1;
            3: dbus_id[r.idx] = 4'hf;
            4: ibus_id[r.idx] = 4'hf;
            5: ls_replica = ~ls_main;
            default: fake_fault[r.idx] = 1'b1;
        endcase
        @(negedge sys_clk);
        idle();
        if (r.kind == 0)
            chk(FAULT_W'({xp_resp_valid[r.idx], xp_resp_err[r.idx]}), FAULT_W'(2'b11));
        repeat (3) @(negedge sys_clk);
        chk(fault_q, exp);
    endtask
    initial
    begin
        ls_main = 32'h0f0f_3c3c;
        ls_enable = 1'b1;
        xp_addr = '{32'h8000, 32'h8000, 32'h8000, 32'h8000};
        region_lo = '0;
        region_hi = '0;
        region_lo[0] = 32'h1000;
        region_hi[0] = 32'h1fff;
        region_rd = 4'h1;
        region_wr = 4'h0;
        foreach (fb_sent[i]) fb_sent[i] = 8'(i * 3 + 1);
        rmw_req = '0;
        rmw_addr = '{32'h40, 32'h80};
        rmw_wdata = '{32'hffff_0000, 32'hffff_0000};
        rmw_wmask = '{32'h00ff_00ff, 32'h00ff_00ff};
        idle();
        do_reset();
        chk(fault_q, FAULT_RST);
        chk(FAULT_W'({xp_resp_valid, xp_resp_err, slv_rd, slv_wr, slv_lock}), '0);
        foreach (rows[i]) run_row(rows[i]);
        // Back-to-back read granted, then write to a read-only region
        do_reset();
        xp_addr[1] = 32'h1800;
        xp_valid[1] = 1'b1;
        @(negedge sys_clk);
        xp_write[1] = 1'b1;
        chk(FAULT_W'({xp_resp_valid[1], xp_resp_err[1]}), FAULT_W'(2'b10));
        @(negedge sys_clk);
        idle();
        chk(FAULT_W'({xp_resp_valid[1], xp_resp_err[1]}), FAULT_W'(2'b11));
        repeat (2) @(negedge sys_clk);
        chk(fault_q, FAULT_W'(1) << 32);
        // Lockstep off: only the disable fault, mismatch ignored meanwhile
        do_reset();
        ls_enable = 1'b0;
        ls_replica = ~ls_main;
        repeat (3) @(negedge sys_clk);
        chk(fault_q, FAULT_W'(1) << 111);
        ls_enable = 1'b1;
        idle();
        // Both rmw lanes at once, prompt and slow slave
        do_reset();
        seen = '0;
        rmw_req = 2'b11;
        for (int n = 0; n < 30 && seen != 2'b11; n++)
        begin
            @(negedge sys_clk);
            seen |= rmw_done;
            rmw_req &= ~rmw_done;
        end
        if (seen !== 2'b11)
        begin
            num_errors++;
            finish_test();
        end
        chk(FAULT_W'({mem[0], mem[1]}), FAULT_W'({2{32'h12ff_5600}}));
        // Address taken at request time must still face the slave
        chk(FAULT_W'({slv_addr[0], slv_addr[1]}), FAULT_W'({32'h40, 32'h80}));
        chk(fault_q, '0);
        finish_test();
    end
    initial
    begin
        repeat (20000) @(negedge sys_clk);
        num_errors++;
        finish_test();
    end
endmodule
bind bcfr_top bcfr_props #(.CORE_ID(CORE_ID)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .xp_valid(xp_valid), .xp_resp_valid(xp_resp_valid), .xp_resp_err(xp_resp_err),
    .fb_valid(fb_valid), .fb_sent(fb_sent), .fb_back(fb_back), .slv_rd(slv_rd),
    .slv_wr(slv_wr), .slv_lock(slv_lock), .slv_ack(slv_ack), .rmw_done(rmw_done),
    .mchk(mchk), .dbus_valid(dbus_valid), .dbus_id(dbus_id), .ls_enable(ls_enable),
    .fake_fault(fake_fault), .fault_q(fault_q));
